// ===== core/pt_consts.svh
/*
 * Offsets, field positions and reset values of the paired timer block.
 * Assumes byte addresses on a 13-bit Avalon-MM address bus.
 */
// What this block does
// R1 - Timer runs only while its enable bit is set.
// R2 - Halt-in-idle bit stops the timer during Idle.
// R3 - External clock: gate bit ignored and reads zero.
// R4 - Internal clock: gate bit switches gated accumulation.
// R5 - Prescale field divides by 1,2,4,8,16,32,64,256.
// R6 - Pairing bit exists only on even timers.
// R7 - Paired: odd timer's control bits have no effect, except its halt-in-idle bit.
// R8 - Software clears odd halt bit for idle running.
// R9 - Pair uses even registers and pin, odd flag.
// R10 - ADC trigger comes only from timer three or the two/three pair.
// R11 - Clear, set, invert aliases at plus 4, 8, C.
// R12 - Unimplemented control bits read as zero.
// R13 - Software avoids access right after disabling.
// R14 - Source bit picks pin edges or peripheral clock.
// R15 - Pairing bit joins even and odd into 32 bits.
// R16 - Count up; match resets to zero, sets flag.
`ifndef PT_CONSTS_SVH
`define PT_CONSTS_SVH

`define PT_OFF_CTRL2      13'h0800
`define PT_OFF_COUNT2     13'h0810
`define PT_OFF_PERIOD2    13'h0820
`define PT_OFF_CTRL3      13'h0a00
`define PT_OFF_COUNT3     13'h0a10
`define PT_OFF_PERIOD3    13'h0a20
`define PT_OFF_CTRL4      13'h0c00
`define PT_OFF_COUNT4     13'h0c10
`define PT_OFF_PERIOD4    13'h0c20
`define PT_OFF_CTRL5      13'h0f00
`define PT_OFF_COUNT5     13'h0e10
`define PT_OFF_PERIOD5    13'h0e20
`define PT_OFF_STATUS     13'h1000
`define PT_OFF_MASK       13'h1010

`define PT_OP_WRITE       2'h0
`define PT_OP_CLEAR       2'h1
`define PT_OP_SET         2'h2
`define PT_OP_INVERT      2'h3

`define PT_BIT_ON         15
`define PT_BIT_HALT_IDLE  13
`define PT_BIT_GATE       7
`define PT_BIT_PS_HI      6
`define PT_BIT_PS_LO      4
`define PT_BIT_PAIR       3
`define PT_BIT_SRC        1

`define PT_CTRL_IMPL_EVEN 16'ha0fa
`define PT_CTRL_IMPL_ODD  16'ha0f2
`define PT_CTRL_RESET     16'h0000
`define PT_COUNT_RESET    16'h0000
`define PT_PERIOD_RESET   16'hffff

`endif

// ===== core/pt_pkg.sv
/*
 * Types of the paired timer block.
 * Assumes four timers of 16 bits each.
 */
package pt_pkg;

	typedef enum logic [1:0]
	{
		PT_KIND_CTRL   = 2'b00,
		PT_KIND_COUNT  = 2'b01,
		PT_KIND_PERIOD = 2'b10,
		PT_KIND_NONE   = 2'b11
	} pt_kind_t;

	typedef struct packed
	{
		logic [3:0][15:0] ctrl;
		logic [3:0][15:0] count;
		logic [3:0][15:0] period;
		logic [3:0][7:0]  pre;
		logic [3:0]       status;
		logic [3:0]       mask;
		logic [3:0]       pinMeta;
		logic [3:0]       pinSync;
		logic [3:0]       pinPrev;
		logic             ack;
		logic [31:0]      rdata;
		logic             adc;
	} pt_state_t;

endpackage : pt_pkg

// ===== core/pt_timers.sv
/*
 * Four 16-bit timers, pairable two and three, four and five, behind Avalon-MM.
 * Assumes idleMode comes from logic on clk, count pins are asynchronous.
 */
`include "pt_consts.svh"

module pt_timers #(
	parameter int CountWidth = 16
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rstn,
	// Avalon-MM slave.
	input  wire logic [12:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output      logic [31:0] avs_readdata,
	output      logic        avs_waitrequest,
	// Chip and pins.
	input  wire logic        idleMode,
	input  wire logic [3:0]  extCountPin,
	// Events.
	output      logic        irq,
	output      logic        adcTrigger
);

	if (CountWidth != 16)
	begin : gBadWidth
		$error("pt_timers supports only 16-bit timers.");
	end

	localparam logic [3:0][12:0] CtrlOff   = {`PT_OFF_CTRL5, `PT_OFF_CTRL4,
		`PT_OFF_CTRL3, `PT_OFF_CTRL2};
	localparam logic [3:0][12:0] CountOff  = {`PT_OFF_COUNT5, `PT_OFF_COUNT4,
		`PT_OFF_COUNT3, `PT_OFF_COUNT2};
	localparam logic [3:0][12:0] PeriodOff = {`PT_OFF_PERIOD5, `PT_OFF_PERIOD4,
		`PT_OFF_PERIOD3, `PT_OFF_PERIOD2};

	localparam pt_pkg::pt_state_t ResetState = '{
		ctrl:    {4{`PT_CTRL_RESET}},
		count:   {4{`PT_COUNT_RESET}},
		period:  {4{`PT_PERIOD_RESET}},
		default: '0
	};

	pt_pkg::pt_state_t s_r;
	pt_pkg::pt_state_t s_nxt;

	logic        request;
	logic [3:0]  decoded;
	logic [1:0]  kind;
	logic [1:0]  idx;
	logic [1:0]  aliasOp;
	logic [15:0] laneMask;
	logic [15:0] wrData;
	logic [31:0] rdValue;
	logic [3:0]  presTick;
	logic [3:0]  matchEv;
	logic [3:0]  statusClr;

	// Returns {kind, timer index}; aliases share the base's 16-byte slot.
	function automatic logic [3:0] regDecode(input logic [12:0] a);
		logic [3:0] r;
		r = {pt_pkg::PT_KIND_NONE, 2'h0};
		for (int t = 0; t < 4; t++)
		begin
			if (a[12:4] == CtrlOff[t][12:4])
				r = {pt_pkg::PT_KIND_CTRL, 2'(t)};
			if (a[12:4] == CountOff[t][12:4])
				r = {pt_pkg::PT_KIND_COUNT, 2'(t)};
			if (a[12:4] == PeriodOff[t][12:4])
				r = {pt_pkg::PT_KIND_PERIOD, 2'(t)};
		end
		return r;
	endfunction : regDecode

	// Last prescaler count before a prescaled tick.
	function automatic logic [7:0] presMax(input logic [2:0] sel);
		logic [7:0] m;
		m = 8'h00;
		case (sel)
			3'h0:    m = 8'h00;
			3'h1:    m = 8'h01;
			3'h2:    m = 8'h03;
			3'h3:    m = 8'h07;
			3'h4:    m = 8'h0f;
			3'h5:    m = 8'h1f;
			3'h6:    m = 8'h3f;
			3'h7:    m = 8'hff;
			default: m = 8'h00;
		endcase
		return m; // see R5
	endfunction : presMax

	function automatic logic [15:0] applyOp(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] op);
		logic [15:0] v;
		v = wd;
		case (op)
			`PT_OP_WRITE:  v = wd;
			`PT_OP_CLEAR:  v = old & ~wd;
			`PT_OP_SET:    v = old | wd;
			`PT_OP_INVERT: v = old ^ wd;
			default:       v = wd;
		endcase
		return v; // see R11
	endfunction : applyOp

	// Pairing bit only on even timers.
	function automatic logic [15:0] implMask(input logic odd);
		return odd ? `PT_CTRL_IMPL_ODD : `PT_CTRL_IMPL_EVEN; // see R6
	endfunction : implMask

	function automatic logic [15:0] ctrlRead(input logic [15:0] v, input logic odd);
		logic [15:0] r;
		r = v & implMask(odd); // see R12
		if (v[`PT_BIT_SRC])
			r[`PT_BIT_GATE] = 1'b0; // see R3
		return r;
	endfunction : ctrlRead

	// Status and mask have no aliases, so only their exact word is decoded.
	function automatic logic isWord(input logic [12:0] a, input logic [12:0] off);
		return a[12:2] == off[12:2];
	endfunction : isWord

	assign request         = avs_read | avs_write;
	assign avs_waitrequest = request & ~s_r.ack;
	assign avs_readdata    = s_r.rdata;
	assign adcTrigger      = s_r.adc;
	assign irq             = |(s_r.status & s_r.mask);

	always_comb
	begin
		s_nxt     = s_r;
		decoded   = regDecode(avs_address);
		kind      = decoded[3:2];
		idx       = decoded[1:0];
		aliasOp   = avs_address[3:2];
		laneMask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wrData    = avs_writedata[15:0];
		rdValue   = 32'h0000_0000;
		presTick  = 4'h0;
		matchEv   = 4'h0;
		statusClr = 4'h0;

		// The first stage feeds only the second; edges are seen after both.
		s_nxt.pinMeta = extCountPin;
		s_nxt.pinSync = s_r.pinMeta;
		s_nxt.pinPrev = s_r.pinSync;
		s_nxt.adc     = 1'b0;

		// Prescalers; a paired odd timer takes all but its halt-in-idle bit from its even partner.
		for (int i = 0; i < 4; i++)
		begin
			logic       paired;
			logic       odd;
			logic [1:0] g;
			logic       on;
			logic       src;
			logic       gate;
			logic       halt;
			logic       base;
			base   = 1'b0;
			paired = s_r.ctrl[i & 2][`PT_BIT_PAIR]; // see R15
			odd    = (i % 2) == 1;
			g      = (paired ? 2'(i & 2) : 2'(i)); // see R7, R9
			on     = s_r.ctrl[g][`PT_BIT_ON];
			src    = s_r.ctrl[g][`PT_BIT_SRC];
			gate   = s_r.ctrl[g][`PT_BIT_GATE] & ~src; // see R3, R4
			// A pair also stops in Idle while the odd halt bit is set.
			halt   = idleMode & (s_r.ctrl[g][`PT_BIT_HALT_IDLE] |
				(paired & s_r.ctrl[(i & 2) + 1][`PT_BIT_HALT_IDLE])); // see R2, R8
			if (src)
				base = s_r.pinSync[g] & ~s_r.pinPrev[g]; // see R14
			else if (gate)
				base = s_r.pinSync[g]; // see R4
			else
				base = 1'b1; // see R14
			if ((paired && odd) || !on)
				s_nxt.pre[i] = 8'h00; // see R1
			else if (!halt && base)
			begin
				if (s_r.pre[i] >= presMax(s_r.ctrl[g][`PT_BIT_PS_HI:`PT_BIT_PS_LO]))
				begin
					s_nxt.pre[i] = 8'h00;
					presTick[i]  = 1'b1; // see R5
				end
				else
					s_nxt.pre[i] = s_r.pre[i] + 8'h01;
			end
		end

		// Counters, per pair.
		for (int p = 0; p < 2; p++)
		begin
			int e;
			int o;
			e = 2 * p;
			o = e + 1;
			if (s_r.ctrl[e][`PT_BIT_PAIR])
			begin
				if (presTick[e])
				begin
					if ({s_r.count[o], s_r.count[e]} == {s_r.period[o], s_r.period[e]})
					begin
						s_nxt.count[o] = 16'h0000;
						s_nxt.count[e] = 16'h0000;
						matchEv[o]     = 1'b1; // see R9, R16
					end
					else
						{s_nxt.count[o], s_nxt.count[e]} =
							{s_r.count[o], s_r.count[e]} + 32'h0000_0001; // see R15
				end
			end
			else
			begin
				for (int j = e; j <= o; j++)
				begin
					if (presTick[j])
					begin
						if (s_r.count[j] == s_r.period[j])
						begin
							s_nxt.count[j] = 16'h0000;
							matchEv[j]     = 1'b1; // see R16
						end
						else
							s_nxt.count[j] = s_r.count[j] + 16'h0001; // see R16
					end
				end
			end
		end

		// Timer three's flag is also the pair's flag, so one tap serves both modes.
		s_nxt.adc = matchEv[1]; // see R10

		// Read path: data is captured on the wait cycle and stands on the answer.
		case (kind)
			pt_pkg::PT_KIND_CTRL:   rdValue = {16'h0000, ctrlRead(s_r.ctrl[idx], idx[0])};
			pt_pkg::PT_KIND_COUNT:  rdValue = {16'h0000, s_r.count[idx]};
			pt_pkg::PT_KIND_PERIOD: rdValue = {16'h0000, s_r.period[idx]};
			default:
			begin
				if (isWord(avs_address, `PT_OFF_STATUS))
					rdValue = {28'h0000000, s_r.status};
				else if (isWord(avs_address, `PT_OFF_MASK))
					rdValue = {28'h0000000, s_r.mask};
				else
					rdValue = 32'h0000_0000;
			end
		endcase
		s_nxt.ack = request & ~s_r.ack;
		if (avs_read && !s_r.ack)
			s_nxt.rdata = rdValue;

		// Writes land on the answer cycle and override counting in that cycle.
		if (avs_write && s_r.ack)
		begin
			case (kind)
				pt_pkg::PT_KIND_CTRL:
					s_nxt.ctrl[idx] = ((s_r.ctrl[idx] & ~laneMask) |
						(applyOp(s_r.ctrl[idx], wrData, aliasOp) & laneMask)) &
						implMask(idx[0]); // see R11, R12
				pt_pkg::PT_KIND_COUNT:
					s_nxt.count[idx] = (s_r.count[idx] & ~laneMask) |
						(applyOp(s_r.count[idx], wrData, aliasOp) & laneMask); // see R11
				pt_pkg::PT_KIND_PERIOD:
					s_nxt.period[idx] = (s_r.period[idx] & ~laneMask) |
						(applyOp(s_r.period[idx], wrData, aliasOp) & laneMask); // see R11
				default:
				begin
					if (isWord(avs_address, `PT_OFF_STATUS) && avs_byteenable[0])
						statusClr = avs_writedata[3:0];
					else if (isWord(avs_address, `PT_OFF_MASK) && avs_byteenable[0])
						s_nxt.mask = avs_writedata[3:0];
				end
			endcase
		end

		// A match in the clearing cycle survives the clear.
		s_nxt.status = (s_r.status & ~statusClr) | matchEv; // see R16
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s_r <= ResetState;
		else
			s_r <= s_nxt;
	end

endmodule : pt_timers

// ===== tb/pt_timers_sva.sv
/* Port checks of pt_timers.
   Assumes one clock and a synchronous rstn. */
module pt_timers_sva (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rstn,
	// Bus.
	input wire logic [12:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Pins and events.
	input wire logic        idleMode,
	input wire logic [3:0]  extCountPin,
	input wire logic        irq,
	input wire logic        adcTrigger
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	wire logic rdEnd = avs_read && !avs_waitrequest;
	wire logic ctl   = rdEnd && avs_address[7:4] == 4'h0 && !avs_address[12];
	AST_UPPER: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("Upper half set.");
	AST_EVEN: assert property (ctl && !avs_address[9] |->
		(avs_readdata[15:0] & 16'h5f05) == 16'h0000) else $error("Even control.");
	AST_ODD: assert property (ctl && avs_address[9] |->
		(avs_readdata[15:0] & 16'h5f0d) == 16'h0000) else $error("Odd control.");
	AST_GATE: assert property (ctl && avs_readdata[1] |-> !avs_readdata[7])
		else $error("Gate bit shown.");
	AST_WAIT: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
		else $error("No wait cycle.");
	AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("Late answer.");
	AST_QUIET: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("Stray wait.");
	AST_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("Read data moved.");
endmodule : pt_timers_sva

bind pt_timers pt_timers_sva u_sva (.clk(clk), .rstn(rstn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .idleMode(idleMode),
	.extCountPin(extCountPin), .irq(irq), .adcTrigger(adcTrigger));

// ===== tb/test_paired_16_32_bit_timers.sv
/* Self-checking bench of pt_timers.
   Assumes the port checker is bound in. */
module test_paired_16_32_bit_timers;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic        idleMode = 1'h0, avs_waitrequest, irq, adcTrigger;
	logic [12:0] avs_address = 13'h0000, ad;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q, p;
	logic [3:0]  extCountPin = 4'h0, be = 4'hf;
	int          n_fail = 0, checks_done = 0, adcN = 0, a0, n, m, d;
	time         t1;
	logic [12:0] cA [4] = '{13'h0800, 13'h0a00, 13'h0c00, 13'h0f00};
	always #50 clk = ~clk;
	always @(posedge clk) if (adcTrigger === 1'h1) adcN <= adcN + 1;
	pt_timers uut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.idleMode(idleMode), .extCountPin(extCountPin), .irq(irq), .adcTrigger(adcTrigger));
	task automatic chk(input logic [31:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// Samples on the falling edge so that no check races the design's own updates.
	task automatic hold(input bit forIrq);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while ((forIrq ? irq !== 1'h1 : avs_waitrequest !== 1'h0) && n < 3001);
		if (n > 3000)
		begin
			n_fail++;
			complete_run();
		end
	endtask : hold
	// The request stands until waitrequest is seen low at a rising edge.
	task automatic bus(input logic w, input logic [12:0] a, input logic [15:0] v);
		int k;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {16'h0000, v};
		avs_write <= w;
		avs_read <= !w;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (avs_waitrequest !== 1'h0 && k < 3001);
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		if (k > 3000)
		begin
			n_fail++;
			complete_run();
		end
	endtask : bus
	task automatic ci(input logic e);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask : ci
	initial
	begin
		void'($urandom(26317));
		repeat (8) @(posedge clk);
		rstn <= 1'h1;
		bus(1, 13'h0100, 16'hffff);
		bus(0, 13'h0100, 16'h0000);
		chk(q, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			bus(0, cA[i], 16'h0000);
			chk(q, 32'h0);
			bus(1, cA[i], 16'hffff);
			bus(0, cA[i], 16'h0000);
			chk(q, i % 2 ? 32'ha072 : 32'ha07a);
			bus(1, cA[i], 16'h0000);
			for (int k = 1; k < 3; k++)
			begin
				ad = 13'h0800 + 13'(i * 512 + k * 16);
				bus(0, ad, 16'h0000);
				m = k == 2 ? 32'hffff : 0;
				chk(q, 32'(m));
				for (int j = 0; j < 4; j++)
				begin
					d = $urandom_range(32'hffff);
					bus(1, ad + 13'(4 * j), d[15:0]);
					m = j == 0 ? d : j == 1 ? m & ~d : j == 2 ? m | d : m ^ d;
					bus(0, ad, 16'h0000);
					chk(q, 32'(m));
				end
			end
		end
		bus(1, 13'h1010, 16'h0003);
		bus(1, 13'h0820, 16'h0007);
		a0 = adcN;
		for (int s = 0; s < 8; s++)
		begin
			bus(1, 13'h0810, 16'h0000);
			bus(1, 13'h0800, 16'h8000 | 16'(s << 4));
			hold(1);
			t1 = $time;
			bus(1, 13'h1000, 16'h0001);
			hold(1);
			chk(32'(($time - t1) / 100), 32'(s == 7 ? 2048 : 8 << s));
			bus(1, 13'h0800, 16'h0000);
			bus(1, 13'h1000, 16'h000f);
		end
		chk(32'(adcN - a0), 32'h0);
		bus(1, 13'h0a10, 16'h0000);
		bus(1, 13'h0a20, 16'h0003);
		bus(1, 13'h0a00, 16'h8000);
		hold(1);
		bus(1, 13'h0a00, 16'h0000);
		chk(32'(adcN > a0), 32'h1);
		bus(0, 13'h1000, 16'h0000);
		chk(q, 32'h2);
		bus(1, 13'h1010, 16'h0000);
		ci(0);
		bus(1, 13'h1010, 16'h0003);
		ci(1);
		bus(1, 13'h1000, 16'h0002);
		ci(0);
		bus(1, 13'h0810, 16'hfff0);
		bus(1, 13'h0a10, 16'h0000);
		bus(1, 13'h0820, 16'h0000);
		bus(1, 13'h0a20, 16'h0001);
		bus(1, 13'h0a00, 16'h0072);
		a0 = adcN;
		bus(1, 13'h0800, 16'h8008);
		hold(1);
		bus(0, 13'h1000, 16'h0000);
		chk(q, 32'h2);
		chk(32'(adcN > a0), 32'h1);
		bus(1, 13'h0800, 16'h0000);
		bus(1, 13'h0c20, 16'hffff);
		bus(1, 13'h0c00, 16'ha000);
		idleMode <= 1'h1;
		bus(0, 13'h0c10, 16'h0000);
		p = q;
		bus(0, 13'h0c10, 16'h0000);
		chk(q, p);
		bus(1, 13'h0c00, 16'h8000);
		bus(0, 13'h0c10, 16'h0000);
		chk(32'(q != p), 32'h1);
		bus(1, 13'h0c00, 16'h0000);
		bus(0, 13'h0c10, 16'h0000);
		p = q;
		bus(0, 13'h0c10, 16'h0000);
		chk(q, p);
		idleMode <= 1'h0;
		bus(1, 13'h0820, 16'hffff);
		bus(1, 13'h0810, 16'h0000);
		bus(1, 13'h0800, 16'h8080);
		m = $urandom_range(40, 5);
		extCountPin[0] <= 1'h1;
		repeat (m) @(posedge clk);
		extCountPin[0] <= 1'h0;
		repeat (4) @(posedge clk);
		bus(0, 13'h0810, 16'h0000);
		chk(q, 32'(m));
		bus(1, 13'h0e20, 16'hffff);
		bus(1, 13'h0e10, 16'h0000);
		bus(1, 13'h0f00, 16'h8002);
		m = $urandom_range(12, 3);
		repeat (m)
		begin
			extCountPin[3] <= 1'h1;
			repeat (4) @(posedge clk);
			extCountPin[3] <= 1'h0;
			repeat (4) @(posedge clk);
		end
		bus(0, 13'h0e10, 16'h0000);
		chk(q, 32'(m));
		bus(1, 13'h1000, 16'h000f);
		bus(1, 13'h0c10, 16'h0000);
		bus(1, 13'h0e10, 16'h0000);
		bus(1, 13'h0c20, 16'h0003);
		bus(1, 13'h0e20, 16'h0000);
		bus(1, 13'h0f00, 16'h2000);
		idleMode <= 1'h1;
		bus(1, 13'h0c00, 16'h8008);
		bus(0, 13'h0c10, 16'h0000);
		chk(q, 32'h0);
		bus(1, 13'h0f00, 16'h0000);
		bus(1, 13'h1010, 16'h0008);
		hold(1);
		bus(0, 13'h1000, 16'h0000);
		chk(q, 32'h8);
		idleMode <= 1'h0;
		rstn <= 1'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		ci(0);
		bus(0, 13'h0c20, 16'h0000);
		chk(q, 32'hffff);
		bus(0, 13'h0c00, 16'h0000);
		chk(q, 32'h0);
		bus(0, 13'h1000, 16'h0000);
		chk(q, 32'h0);
		be <= 4'h1;
		bus(1, 13'h0c20, 16'h1234);
		be <= 4'hf;
		bus(0, 13'h0c20, 16'h0000);
		chk(q, 32'hff34);
		complete_run();
	end
endmodule : test_paired_16_32_bit_timers
